/* File: shared/mba_pkg.sv */
/*
  Constants and types for the modulo / bit-reversed address generator.
  Assumes a 16-bit data space and a 32-bit AHB-Lite register window.
*/
`default_nettype none

package mba_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W  = 16;
  localparam int SEL_W   = 4;
  localparam int PIVOT_W = 15;
  localparam int OFS_W   = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_MODCTL   = 8'h00;
  localparam logic [7:0] OFS_BRCTL    = 8'h04;
  localparam logic [7:0] OFS_MODSTART = 8'h08;
  localparam logic [7:0] OFS_MODEND   = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int MODEN_BIT  = 15;
  localparam int BRSEL_LSB  = 8;
  localparam int MODSEL_LSB = 0;
  localparam int BITREV_EN_BIT = 15;
  localparam int STAT_WRAP  = 16;
  localparam int STAT_BREV  = 17;

  ////////////////////////////////////////////////////////////////////////////
  // Masks and reset values
  localparam logic [15:0] MODCTL_MASK  = 16'h8F0F;
  localparam logic [15:0] MODCTL_RST   = 16'h0F00;
  localparam logic [15:0] BRCTL_RST    = 16'h0000;
  localparam logic [15:0] MODSTART_RST = 16'h0000;
  localparam logic [15:0] MODEND_RST   = 16'hFFFF;
  localparam logic [3:0]  STACK_SEL    = 4'hF;
  localparam logic [2:0]  HSIZE_WORD   = 3'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer steps in bytes
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

  ////////////////////////////////////////////////////////////////////////////
  // Addressing modes offered by the pipeline
  typedef enum logic [2:0] {
    MODE_IND,
    MODE_POSTINC,
    MODE_POSTDEC,
    MODE_PREINC,
    MODE_PREDEC,
    MODE_REGOFS
  } mba_mode_t;

endpackage : mba_pkg

`default_nettype wire

/* File: design/mba_bitrev_add.sv */
/*
  Reverse-carry adder: adds two words with the carry running from the
  most significant bit towards the least.
  Assumes the caller aligns the buffer so the wrap stays inside it.
*/
`timescale 1ns/10ps
`default_nettype none

module mba_bitrev_add #(
  parameter int W = 15
) (
  // Operands
  input  wire logic [W-1:0] base,
  input  wire logic [W-1:0] pivot,
  // Result
  output logic      [W-1:0] sum
);

  logic [W-1:0] baseRev;
  logic [W-1:0] pivotRev;
  logic [W-1:0] sumRev;

  ////////////////////////////////////////////////////////////////////////////
  // Mirror, add, mirror back
  for (genvar i = 0; i < W; i++) begin : g_rev
    assign baseRev[i]  = base[W-1-i];
    assign pivotRev[i] = pivot[W-1-i];
    assign sum[i]      = sumRev[W-1-i];
  end

  // Carry out of the top drops on purpose: that is the wrap
  assign sumRev = W'(baseRev + pivotRev);

endmodule : mba_bitrev_add

`default_nettype wire

/* File: design/mba_modulo_bitrev_agu.sv */
/*
  Effective-address generator with modulo and bit-reversed correction,
  plus an AHB-Lite register slave for its control registers.
  Assumes the pipeline supplies pointer contents and writes back the
  returned value itself; one request per cycle at most.
*/
`timescale 1ns/10ps
`default_nettype none

module mba_modulo_bitrev_agu (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic      [31:0]       hrdata,
  output logic                   hresp,
  // Address request from the pipeline
  input  wire logic              reqValid,
  input  wire logic [3:0]        reqPtrSel,
  input  wire mba_pkg::mba_mode_t reqMode,
  input  wire logic              reqByte,
  input  wire logic              reqWrite,
  input  wire logic [15:0]       reqPtr,
  input  wire logic [15:0]       reqOffset,
  // Address result to the pipeline
  output logic                   eaValid,
  output logic      [15:0]       effAddr,
  output logic                   wbEn,
  output logic      [3:0]        wbSel,
  output logic      [15:0]       wbData,
  output logic                   bitrevActive,
  output logic                   moduloWrapped
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [15:0] modulo_control_reg_r;
  logic [15:0] modulo_control_reg_nxt;
  logic [15:0] bitrev_control_reg_r;
  logic [15:0] bitrev_control_reg_nxt;
  logic [15:0] modStart_r;
  logic [15:0] modStart_nxt;
  logic [15:0] modEnd_r;
  logic [15:0] modEnd_nxt;
  logic [17:0] status_r;
  logic        wrPend_r;
  logic [7:0]  wrAddr_r;
  logic        hreadyout_r;
  logic [31:0] hrdata_r;
  logic        hresp_r;

  logic        busAccept;
  logic [31:0] readValue;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase; zero wait states, always OKAY
  assign busAccept = hsel && htrans[1] && hready;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end else begin
      wrPend_r <= busAccept && hwrite && (hsize == mba_pkg::HSIZE_WORD);
      wrAddr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hreadyout_r <= 1'b0;
      hresp_r     <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data-phase writes; next values also feed reads for forwarding
  always_comb begin
    modulo_control_reg_nxt = modulo_control_reg_r;
    bitrev_control_reg_nxt = bitrev_control_reg_r;
    modStart_nxt           = modStart_r;
    modEnd_nxt             = modEnd_r;
    if (wrPend_r) begin
      unique case (wrAddr_r)
        mba_pkg::OFS_MODCTL:
          modulo_control_reg_nxt = hwdata[15:0] & mba_pkg::MODCTL_MASK;
        mba_pkg::OFS_BRCTL:
          bitrev_control_reg_nxt = hwdata[15:0];
        mba_pkg::OFS_MODSTART:
          modStart_nxt = hwdata[15:0];
        mba_pkg::OFS_MODEND:
          modEnd_nxt = hwdata[15:0];
        default: ;
      endcase
    end
  end

  // New control values steer requests from the cycle after the data phase
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      modulo_control_reg_r <= mba_pkg::MODCTL_RST;
      bitrev_control_reg_r <= mba_pkg::BRCTL_RST;
      modStart_r           <= mba_pkg::MODSTART_RST;
      modEnd_r             <= mba_pkg::MODEND_RST;
    end else begin
      modulo_control_reg_r <= modulo_control_reg_nxt;
      bitrev_control_reg_r <= bitrev_control_reg_nxt;
      modStart_r           <= modStart_nxt;
      modEnd_r             <= modEnd_nxt;
    end
  end

  always_comb begin
    readValue = 32'h0000_0000;
    unique case (haddr[7:0])
      mba_pkg::OFS_MODCTL:   readValue[15:0] = modulo_control_reg_nxt;
      mba_pkg::OFS_BRCTL:    readValue[15:0] = bitrev_control_reg_nxt;
      mba_pkg::OFS_MODSTART: readValue[15:0] = modStart_nxt;
      mba_pkg::OFS_MODEND:   readValue[15:0] = modEnd_nxt;
      mba_pkg::OFS_STATUS:   readValue[17:0] = status_r;
      default: ;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hrdata_r <= 32'h0000_0000;
    end else if (busAccept && !hwrite) begin
      hrdata_r <= readValue;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hrdata    = hrdata_r;
  assign hresp     = hresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Control fields
  logic       modEnable;
  logic [3:0] modSel;
  logic [3:0] bitrev_pointer_select;
  logic       bitrev_enable;
  logic [14:0] bitrev_pivot;

  assign modEnable             = modulo_control_reg_r[mba_pkg::MODEN_BIT];
  assign modSel                = modulo_control_reg_r[mba_pkg::MODSEL_LSB +: mba_pkg::SEL_W];
  assign bitrev_pointer_select = modulo_control_reg_r[mba_pkg::BRSEL_LSB +: mba_pkg::SEL_W];
  assign bitrev_enable         = bitrev_control_reg_r[mba_pkg::BITREV_EN_BIT];
  assign bitrev_pivot          = bitrev_control_reg_r[mba_pkg::PIVOT_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Mode qualification
  logic        modOn;
  logic        brOn;
  logic        isInc;
  logic [15:0] step;

  assign modOn = modEnable && (reqPtrSel == modSel);

  assign isInc = (reqMode == mba_pkg::MODE_PREINC) || (reqMode == mba_pkg::MODE_POSTINC);

  // X generator only; writes of words only, stack pointer excluded
  assign brOn = bitrev_enable
             && (bitrev_pointer_select != mba_pkg::STACK_SEL)
             && (reqPtrSel == bitrev_pointer_select)
             && isInc && reqWrite && !reqByte;

  assign step = reqByte ? mba_pkg::STEP_BYTE : mba_pkg::STEP_WORD;

  ////////////////////////////////////////////////////////////////////////////
  // Ordinary arithmetic and modulo wrap
  logic [15:0] target;
  logic        goesDown;
  logic        modifies;
  logic [15:0] modLen;
  logic [15:0] corrected;
  logic        wrapped;

  always_comb begin
    target   = reqPtr;
    goesDown = 1'b0;
    modifies = 1'b1;
    unique case (reqMode)
      mba_pkg::MODE_POSTINC,
      mba_pkg::MODE_PREINC: target = reqPtr + step;
      mba_pkg::MODE_POSTDEC,
      mba_pkg::MODE_PREDEC: begin
        target   = reqPtr - step;
        goesDown = 1'b1;
      end
      mba_pkg::MODE_REGOFS: begin
        target   = reqPtr + reqOffset;
        goesDown = reqOffset[15];
      end
      default: modifies = 1'b0;
    endcase
  end

  assign modLen = 16'(modEnd_r - modStart_r + 16'h0001);

  // Beyond the bound, not only equal, so large steps still fold back
  always_comb begin
    corrected = target;
    wrapped   = 1'b0;
    if (modOn && modifies) begin
      if (!goesDown && (target > modEnd_r)) begin
        corrected = target - modLen;
        wrapped   = 1'b1;
      end else if (goesDown && (target < modStart_r)) begin
        corrected = target + modLen;
        wrapped   = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit-reversed step on the word index
  logic [14:0] brWordNext;
  logic [15:0] brNext;
  logic [15:0] brBase;

  // Pivot counts words, so it adds at bit 1 of the byte address
  mba_bitrev_add #(
    .W (mba_pkg::PIVOT_W)
  ) u_bitrev_add (
    .base  (reqPtr[15:1]),
    .pivot (bitrev_pivot),
    .sum   (brWordNext)
  );

  assign brNext = {brWordNext, 1'b0};
  assign brBase = {reqPtr[15:1], 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Result selection
  logic [15:0] eaCalc;
  logic        wbCalc;
  logic [15:0] wbValCalc;

  always_comb begin
    eaCalc    = reqPtr;
    wbCalc    = 1'b0;
    wbValCalc = reqPtr;
    if (brOn) begin
      // Step of the mode is dropped in favour of the pivot
      eaCalc    = (reqMode == mba_pkg::MODE_PREINC) ? brNext : brBase;
      wbCalc    = 1'b1;
      wbValCalc = brNext;
    end else begin
      unique case (reqMode)
        mba_pkg::MODE_POSTINC,
        mba_pkg::MODE_POSTDEC: begin
          eaCalc    = reqPtr;
          wbCalc    = 1'b1;
          wbValCalc = corrected;
        end
        mba_pkg::MODE_PREINC,
        mba_pkg::MODE_PREDEC: begin
          eaCalc    = corrected;
          wbCalc    = 1'b1;
          wbValCalc = corrected;
        end
        mba_pkg::MODE_REGOFS: begin
          eaCalc = corrected;
          wbCalc = 1'b0;
        end
        default: begin
          eaCalc = reqPtr;
          wbCalc = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered answer to the pipeline
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      eaValid       <= 1'b0;
      effAddr       <= 16'h0000;
      wbEn          <= 1'b0;
      wbSel         <= 4'h0;
      wbData        <= 16'h0000;
      bitrevActive  <= 1'b0;
      moduloWrapped <= 1'b0;
    end else begin
      eaValid <= reqValid;
      wbEn    <= reqValid && wbCalc;
      if (reqValid) begin
        effAddr       <= eaCalc;
        wbSel         <= reqPtrSel;
        wbData        <= wbValCalc;
        bitrevActive  <= brOn;
        moduloWrapped <= wrapped && !brOn;
      end
    end
  end

  // Last request seen, for software to inspect
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status_r <= 18'h00000;
    end else if (reqValid) begin
      status_r <= {brOn, wrapped && !brOn, eaCalc};
    end
  end

endmodule : mba_modulo_bitrev_agu

`default_nettype wire

/* File: tb/mba_agu_chk.sv */
/*
  Port checker for the address generator.
  Assumes binding to the top module; one clock, synchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none

module mba_agu_chk (
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               reset,
  // Observed ports
  input wire logic               hresp,
  input wire logic               reqValid,
  input wire logic [3:0]         reqPtrSel,
  input wire mba_pkg::mba_mode_t reqMode,
  input wire logic               reqByte,
  input wire logic               reqWrite,
  input wire logic [15:0]        reqPtr,
  input wire logic               eaValid,
  input wire logic [15:0]        effAddr,
  input wire logic               wbEn,
  input wire logic [3:0]         wbSel,
  input wire logic [15:0]        wbData,
  input wire logic               bitrevActive,
  input wire logic               moduloWrapped
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  wire logic incMode;
  assign incMode = reqMode == mba_pkg::MODE_POSTINC || reqMode == mba_pkg::MODE_PREINC;

  sequence s_take;
    reqValid;
  endsequence
  sequence s_brev_out;
    eaValid && bitrevActive;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_answer_next: assert property (s_take |=> eaValid) else $error("answer missing");
  a_answer_only: assert property (!reqValid |=> !eaValid) else $error("answer without request");
  a_ind_plain: assert property (s_take ##0 reqMode == mba_pkg::MODE_IND |=> !wbEn && effAddr == $past(reqPtr))
    else $error("plain indirect address wrong");
  a_ofs_keep: assert property (reqValid && reqMode == mba_pkg::MODE_REGOFS |=> !wbEn)
    else $error("offset mode wrote pointer back");
  a_modify_wb: assert property (s_take ##0 !incMode && reqMode inside {mba_pkg::MODE_POSTDEC, mba_pkg::MODE_PREDEC}
    |=> wbEn && wbSel == $past(reqPtrSel)) else $error("decrement write-back missing");
  a_post_ea: assert property (reqValid && reqMode == mba_pkg::MODE_POSTINC
    |=> wbEn && effAddr == ($past(reqPtr) & {15'h7FFF, !bitrevActive})) else $error("post address wrong");
  a_brev_cause: assert property (reqValid && (!incMode || !reqWrite || reqByte || reqPtrSel == mba_pkg::STACK_SEL)
    |=> !bitrevActive) else $error("bit-reverse on wrong access");
  a_brev_even: assert property (s_brev_out |-> !effAddr[0] && !wbData[0]) else $error("odd bit-reverse address");
  a_brev_first: assert property (s_brev_out |-> !moduloWrapped) else $error("modulo beat bit-reverse");
  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
endmodule : mba_agu_chk

`default_nettype wire

/* File: tb/mba_pipe_model.sv */
/*
  Pipeline model: issues one address request and collects the answer.
  Assumes the generator answers exactly one cycle after the request.
*/
`timescale 1ns/10ps
`default_nettype none

module mba_pipe_model (
  // Clock
  input wire logic                clk_sys,
  // Request
  output logic                    reqValid,
  output logic [3:0]              reqPtrSel,
  output mba_pkg::mba_mode_t      reqMode,
  output logic                    reqByte,
  output logic                    reqWrite,
  output logic [15:0]             reqPtr,
  output logic [15:0]             reqOffset,
  // Answer
  input wire logic                eaValid,
  input wire logic [15:0]         effAddr,
  input wire logic                wbEn,
  input wire logic [15:0]         wbData,
  input wire logic                bitrevActive,
  input wire logic                moduloWrapped
);
  initial begin
    reqValid = 1'b0; reqPtrSel = 4'h0; reqMode = mba_pkg::MODE_IND;
    reqByte = 1'b0; reqWrite = 1'b0; reqPtr = 16'h0000; reqOffset = 16'h0000;
  end

  task send(input logic [3:0] s, input logic [2:0] m, input logic b, input logic w,
            input logic [15:0] p, input logic [15:0] o, output logic [35:0] got);
    @(posedge clk_sys);
    reqValid <= 1'b1; reqPtrSel <= s; reqMode <= mba_pkg::mba_mode_t'(m);
    reqByte <= b; reqWrite <= w; reqPtr <= p; reqOffset <= o;
    @(posedge clk_sys);
    // Pointer and offset are stale once taken; show no leftover value
    reqValid <= 1'b0; reqPtr <= ~p; reqOffset <= ~o;
    // Mid-cycle, while the one-cycle answer stands
    @(negedge clk_sys);
    got = {eaValid, wbEn, effAddr, wbEn ? wbData : 16'h0000, bitrevActive, moduloWrapped};
  endtask : send
endmodule : mba_pipe_model

`default_nettype wire

/* File: tb/modulo_bitrev_address_gen_test.sv */
/*
  Self-checking bench: AHB-Lite master, pipeline model, random requests.
  Assumes the single slave's hreadyout is the bus hready.
*/
`timescale 1ns/10ps
`default_nettype none

module modulo_bitrev_address_gen_test;
  logic clk_sys, reset, hsel, hwrite;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hreadyout, hresp, reqValid, reqByte, reqWrite, eaValid, wbEn, bitrevActive, moduloWrapped;
  wire logic [31:0] hrdata;
  wire logic [3:0] reqPtrSel, wbSel;
  wire logic [15:0] reqPtr, reqOffset, effAddr, wbData;
  wire mba_pkg::mba_mode_t reqMode;
  integer err_count = 0, check_count = 0, seed = 40;
  logic [15:0] modCtl, brCtl, mStart, mEnd;
  logic [35:0] got;
  logic [15:0] rstv [6] = '{mba_pkg::MODCTL_RST, mba_pkg::BRCTL_RST, mba_pkg::MODSTART_RST,
                            mba_pkg::MODEND_RST, 16'h0000, 16'h0000};

  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;

  mba_modulo_bitrev_agu dut (.clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .reqValid, .reqPtrSel, .reqMode, .reqByte,
    .reqWrite, .reqPtr, .reqOffset, .eaValid, .effAddr, .wbEn, .wbSel, .wbData, .bitrevActive, .moduloWrapped);
  mba_pipe_model pipe (.clk_sys, .reqValid, .reqPtrSel, .reqMode, .reqByte, .reqWrite, .reqPtr,
    .reqOffset, .eaValid, .effAddr, .wbEn, .wbData, .bitrevActive, .moduloWrapped);

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= 2'b10; hwrite <= w; hsize <= mba_pkg::HSIZE_WORD;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask : ahb

  task cfg(input logic [15:0] mc, input logic [15:0] bc, input logic [15:0] s, input logic [15:0] e);
    modCtl = mc & mba_pkg::MODCTL_MASK; brCtl = bc; mStart = s; mEnd = e;
    ahb(mba_pkg::OFS_MODSTART, 1'b1, {16'h0000, s});
    ahb(mba_pkg::OFS_MODEND, 1'b1, {16'h0000, e});
    ahb(mba_pkg::OFS_BRCTL, 1'b1, {16'h0000, bc});
    ahb(mba_pkg::OFS_MODCTL, 1'b1, {16'h0000, mc});
    ahb(mba_pkg::OFS_MODCTL, 1'b0, 32'h00000000);
    chk({4'h0, rd}, {20'h00000, modCtl});
  endtask : cfg

  function automatic logic [14:0] rev15(input logic [14:0] v);
    for (int i = 0; i < 15; i++) rev15[i] = v[14-i];
  endfunction : rev15

  function automatic logic [35:0] expect_ea(input logic [3:0] s, input logic [2:0] m, input logic b,
                                            input logic w, input logic [15:0] p, input logic [15:0] o);
    logic [15:0] t, len;
    logic up, md, wr, br;
    up = m == mba_pkg::MODE_POSTINC || m == mba_pkg::MODE_PREINC || (m == mba_pkg::MODE_REGOFS && !o[15]);
    t = (m == mba_pkg::MODE_REGOFS) ? p + o : (up ? p + (b ? mba_pkg::STEP_BYTE : mba_pkg::STEP_WORD)
                                              : p - (b ? mba_pkg::STEP_BYTE : mba_pkg::STEP_WORD));
    md = modCtl[15] && s == modCtl[3:0] && m != mba_pkg::MODE_IND;
    len = mEnd - mStart + 16'h0001;
    wr = md && (up ? t > mEnd : t < mStart);
    if (wr) t = up ? t - len : t + len;
    br = brCtl[15] && modCtl[11:8] != mba_pkg::STACK_SEL && s == modCtl[11:8] && w && !b
      && (m == mba_pkg::MODE_POSTINC || m == mba_pkg::MODE_PREINC);
    if (br) begin
      t = {rev15(rev15(p[15:1]) + rev15(brCtl[14:0])), 1'b0};
      wr = 1'b0;
    end
    case (m)
      mba_pkg::MODE_POSTINC, mba_pkg::MODE_POSTDEC: return {2'b11, br ? {p[15:1], 1'b0} : p, t, br, wr};
      mba_pkg::MODE_PREINC, mba_pkg::MODE_PREDEC:   return {2'b11, t, t, br, wr};
      mba_pkg::MODE_REGOFS:                         return {2'b10, t, 16'h0000, 1'b0, wr};
      default:                                      return {2'b10, p, 16'h0000, 2'b00};
    endcase
  endfunction : expect_ea

  task burst(input int n, input logic [3:0] fs, input logic [15:0] base, input logic [15:0] pmask);
    logic [3:0] s;
    logic [2:0] m;
    logic b, w;
    logic [15:0] p, o;
    logic [35:0] e;
    repeat (n) begin
      s = ($random(seed) & 1) ? fs : 4'($random(seed));
      m = 3'($unsigned($random(seed)) % 6);
      b = 1'($random(seed));
      w = 1'($random(seed));
      p = base | (16'($random(seed)) & pmask);
      o = 16'($random(seed)) & 16'h001F;
      if ($random(seed) & 1) o = -o;
      pipe.send(s, m, b, w, p, o, got);
      e = expect_ea(s, m, b, w, p, o);
      chk(got, e);
    end
    // Status keeps the last answer for software
    ahb(mba_pkg::OFS_STATUS, 1'b0, 32'h00000000);
    chk({4'h0, rd}, {18'h00000, e[1], e[0], e[33:18]});
  endtask : burst

  task end_sim;
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hsel = 1'b0; haddr = 32'h00000000; htrans = 2'b00; hwrite = 1'b0; hsize = 3'h0; hwdata = 32'h00000000;
    reset = 1'b1;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    // Reset values, then one unmapped word
    for (int i = 0; i < 6; i++) begin
      ahb(8'(4 * i), 1'b0, 32'h00000000);
      chk({4'h0, rd}, {20'h00000, rstv[i]});
    end
    $display("Test registers done");
    // Stray bits must read back as zero
    cfg(16'h4080, 16'h0000, 16'h0000, 16'hFFFF);
    burst(40, 4'h3, 16'h0000, 16'hFFFF);
    $display("Test plain done");
    for (int i = 0; i < 16; i++) begin
      cfg(16'h8000 | 16'(i), 16'h0000, 16'h1000, 16'h101F);
      burst(6, 4'(i), 16'h1000, 16'h001F);
    end
    $display("Test modulo done");
    // Same pointer for both corrections; requests follow the control write after its read-back
    cfg(16'h8505, 16'h8010, 16'h2000, 16'h203F);
    burst(40, 4'h5, 16'h2000, 16'h003E);
    $display("Test bit-reverse done");
    cfg(16'h8F0F, 16'h8010, 16'h2000, 16'h203F);
    burst(20, 4'hF, 16'h2000, 16'h003E);
    $display("Test stack select done");
    end_sim;
  end

  initial begin
    #100000;
    err_count++;
    end_sim;
  end
endmodule : modulo_bitrev_address_gen_test

bind mba_modulo_bitrev_agu mba_agu_chk u_chk (.clk_sys, .reset, .hresp, .reqValid, .reqPtrSel, .reqMode,
  .reqByte, .reqWrite, .reqPtr, .eaValid, .effAddr, .wbEn, .wbSel, .wbData, .bitrevActive, .moduloWrapped);

`default_nettype wire
